// ---- shared/sonet_port_pkg.sv ----
// Constants shared by the core to fabric boundary port and its pin sampler
package sonet_port_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int CHANNELS = 8;
    localparam int PAIRS = 4;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_OH_ENABLE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MODE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_PAIR_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] REG_SERIAL_STATUS = 4'h3;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int MODE_BYPASS_BIT = 0;
    localparam logic [DATA_W-1:0] OH_ENABLE_RESET = 8'h00;
    localparam logic MODE_BYPASS_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // Timing of a recovered-clock edge through the sampler, in clocks
    localparam int EDGE_LATENCY = 3;

endpackage

// ---- shared/edge_if.sv ----
// Interface carrying sampled pin levels and their edges between modules
interface edge_if #(
    parameter int WIDTH = 1
);
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;

    modport source (
        output level,
        output rise,
        output fall
    );
    modport sink (
        input level,
        input rise,
        input fall
    );
endinterface

// ---- logic/pin_edge_sync.sv ----
// Three-stage pin sampler with settled level and one-cycle edge pulses
module pin_edge_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins from outside the clock domain
    input wire logic [WIDTH-1:0] pins,
    // Sampled results
    edge_if.source edges
);

    // ------------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] settled_q;

    // Stage one feeds stage two only, to give metastability room
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else begin
            stage1_q <= pins;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settled_q <= '0;
        end else begin
            settled_q <= (stage2_q & stage3_q) | (settled_q & (stage2_q | stage3_q));
        end
    end

    // Edges are seen one cycle before the settled level moves
    assign edges.level = settled_q;
    assign edges.rise = stage2_q & stage3_q & ~settled_q;
    assign edges.fall = ~stage2_q & ~stage3_q & settled_q;

endmodule

// ---- logic/sonet_core_fabric_port.sv ----
// Core side of the boundary between the transceiver core and fabric logic
//
// Our own choices: strobed register access and the register offsets.
module sonet_core_fabric_port #(
    parameter int CHANNELS = sonet_port_pkg::CHANNELS,
    parameter int PAIRS = sonet_port_pkg::PAIRS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [sonet_port_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sonet_port_pkg::DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [sonet_port_pkg::DATA_W-1:0] regReadData,
    // Receive path, core side
    input wire logic [CHANNELS-1:0][sonet_port_pkg::BYTE_W-1:0] rxCoreByte,
    input wire logic [CHANNELS-1:0] recoveredClockIn,
    // Receive path, fabric side
    output logic [CHANNELS-1:0] recoveredChannelClock,
    output logic [CHANNELS-1:0][sonet_port_pkg::BYTE_W-1:0] rxParallelByte,
    // Transmit path
    input wire logic [CHANNELS-1:0][sonet_port_pkg::BYTE_W-1:0] txParallelByte,
    output logic [CHANNELS-1:0][sonet_port_pkg::BYTE_W-1:0] txCoreByte,
    // Serial overhead
    input wire logic [CHANNELS-1:0] overheadClock,
    input wire logic txOverheadClockEnable,
    input wire logic [CHANNELS-1:0] overheadCoreBit,
    output logic [CHANNELS-1:0] overheadSerialOut,
    input wire logic [CHANNELS-1:0] overheadSerialIn,
    output logic [CHANNELS-1:0] overheadCoreIn,
    output logic [CHANNELS-1:0] overheadOutEnableStatus,
    // Protection switching
    input wire logic [PAIRS-1:0] pairProtectSelect,
    input wire logic [CHANNELS-1:0] serialProtectSelect,
    output logic [CHANNELS-1:0] serialProtectApplied
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    generate
        if (PAIRS < 1 || CHANNELS != 2 * PAIRS || CHANNELS > sonet_port_pkg::DATA_W) begin : g_bad
            $error("Channel count must be twice the pair count and fit a register");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin sampling: every asynchronous input goes through one sampler
    // ------------------------------------------------------------------
    localparam int SYNC_W = 4 * CHANNELS + PAIRS + 1;

    edge_if #(.WIDTH(SYNC_W)) pinEdges ();

    pin_edge_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pins({txOverheadClockEnable, pairProtectSelect, serialProtectSelect,
               overheadSerialIn, overheadClock, recoveredClockIn}),
        .edges(pinEdges)
    );

    logic [CHANNELS-1:0] recFall;
    logic [CHANNELS-1:0] ohRise;
    logic [CHANNELS-1:0] ohFall;
    logic [CHANNELS-1:0] ohInLevel;
    logic [CHANNELS-1:0] serialLevel;
    logic [PAIRS-1:0] pairLevel;
    logic ohEnableLevel;

    // Slices of the sampled vector, in the order of the concatenation
    assign recFall = pinEdges.fall[CHANNELS-1:0];
    assign ohRise = pinEdges.rise[2*CHANNELS-1:CHANNELS];
    assign ohFall = pinEdges.fall[2*CHANNELS-1:CHANNELS];
    assign ohInLevel = pinEdges.level[3*CHANNELS-1:2*CHANNELS];
    assign serialLevel = pinEdges.level[4*CHANNELS-1:3*CHANNELS];
    assign pairLevel = pinEdges.level[4*CHANNELS+PAIRS-1:4*CHANNELS];
    assign ohEnableLevel = pinEdges.level[SYNC_W-1];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [CHANNELS-1:0] ohEnable_q;
    logic bypass_q;
    logic [PAIRS-1:0] activeSel_q;
    logic [sonet_port_pkg::DATA_W-1:0] readData_q;
    logic [sonet_port_pkg::DATA_W-1:0] readData_d;

    // Software writes steer overhead enables and the alignment bypass
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ohEnable_q <= CHANNELS'(sonet_port_pkg::OH_ENABLE_RESET);
            bypass_q <= sonet_port_pkg::MODE_BYPASS_RESET;
        end else if (regWrite) begin
            if (regAddr == sonet_port_pkg::REG_OH_ENABLE) begin
                ohEnable_q <= regWriteData[CHANNELS-1:0];
            end
            if (regAddr == sonet_port_pkg::REG_MODE) begin
                bypass_q <= regWriteData[sonet_port_pkg::MODE_BYPASS_BIT];
            end
        end
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        readData_d = sonet_port_pkg::READ_IDLE;
        case (regAddr)
            sonet_port_pkg::REG_OH_ENABLE: begin
                readData_d[CHANNELS-1:0] = ohEnable_q;
            end
            sonet_port_pkg::REG_MODE: begin
                readData_d[sonet_port_pkg::MODE_BYPASS_BIT] = bypass_q;
            end
            sonet_port_pkg::REG_PAIR_STATUS: begin
                readData_d[PAIRS-1:0] = activeSel_q;
            end
            sonet_port_pkg::REG_SERIAL_STATUS: begin
                readData_d[CHANNELS-1:0] = serialProtectApplied;
            end
            default: begin
                readData_d = sonet_port_pkg::READ_IDLE;
            end
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readData_q <= sonet_port_pkg::READ_IDLE;
        end else if (regRead) begin
            readData_q <= readData_d;
        end else begin
            readData_q <= sonet_port_pkg::READ_IDLE;
        end
    end
    assign regReadData = readData_q;

    assign overheadOutEnableStatus = ohEnable_q;

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    // Recovered clock passthrough; a clock, so no flop is put in its way
    assign recoveredChannelClock = recoveredClockIn;

    logic [CHANNELS-1:0] launch;
    logic [CHANNELS-1:0][sonet_port_pkg::BYTE_W-1:0] rxByte_q;

    // Launch timing per mode
    // Bypass launches on the sampled recovered-clock fall, aligned on every
    // system-clock fall; the sampler adds latency but keeps one domain.
    assign launch = bypass_q ? recFall : {CHANNELS{1'b1}};

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_rx
            if (ch % 2 == 0) begin : g_main
                // Low picks protect, high picks main
                always_ff @(negedge clock) begin
                    if (!rst_n) begin
                        rxByte_q[ch] <= '0;
                    end else if (launch[ch]) begin
                        rxByte_q[ch] <= pairLevel[ch/2] ? rxCoreByte[ch] : rxCoreByte[ch+1];
                    end
                end
                // Select applied only when a byte launches
                always_ff @(negedge clock) begin
                    if (!rst_n) begin
                        activeSel_q[ch/2] <= 1'b1;
                    end else if (launch[ch]) begin
                        activeSel_q[ch/2] <= pairLevel[ch/2];
                    end
                end
            end else begin : g_protect
                // Protect channels keep their own port unswitched
                always_ff @(negedge clock) begin
                    if (!rst_n) begin
                        rxByte_q[ch] <= '0;
                    end else if (launch[ch]) begin
                        rxByte_q[ch] <= rxCoreByte[ch];
                    end
                end
            end
        end
    endgenerate
    assign rxParallelByte = rxByte_q;

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    logic [CHANNELS-1:0][sonet_port_pkg::BYTE_W-1:0] txByte_q;

    // Capture on the same rising edge the fabric launches on
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txByte_q <= '0;
        end else begin
            txByte_q <= txParallelByte;
        end
    end
    assign txCoreByte = txByte_q;

    // ------------------------------------------------------------------
    // Serial overhead
    // ------------------------------------------------------------------
    logic [CHANNELS-1:0] ohOut_q;
    logic [CHANNELS-1:0] ohIn_q;

    // Launch out bit on overhead clock rise
    // A disabled channel holds its output low rather than a stale bit.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ohOut_q <= '0;
        end else begin
            ohOut_q <= (ohOut_q & ~ohRise & ohEnable_q) |
                       (overheadCoreBit & ohRise & ohEnable_q);
        end
    end
    assign overheadSerialOut = ohOut_q;

    // Capture in bit on overhead clock fall
    // Insertion only while the fabric holds its enable active
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ohIn_q <= '0;
        end else if (ohEnableLevel) begin
            ohIn_q <= (ohIn_q & ~ohFall) | (ohInLevel & ohFall);
        end
    end
    assign overheadCoreIn = ohIn_q;

    // ------------------------------------------------------------------
    // Serial protection
    // ------------------------------------------------------------------
    logic [CHANNELS-1:0] serialSel_q;

    // Per-channel serial select, registered after sampling
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serialSel_q <= '0;
        end else begin
            serialSel_q <= serialLevel;
        end
    end
    assign serialProtectApplied = serialSel_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_status_mirror: assert property (
        @(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == sonet_port_pkg::REG_OH_ENABLE
        |=> overheadOutEnableStatus == $past(regWriteData[CHANNELS-1:0]))
        else $error("Overhead enable status does not follow the write");

    chk_rx_aligned: assert property (
        @(negedge clock) disable iff (!rst_n)
        !bypass_q && $past(!bypass_q) |-> rxParallelByte[1] == $past(rxCoreByte[1]))
        else $error("Aligned receive byte not launched on the falling edge");

    chk_rx_bypass_hold: assert property (
        @(negedge clock) disable iff (!rst_n)
        bypass_q && $past(bypass_q) && !$past(recFall[1])
        |-> rxParallelByte[1] == $past(rxParallelByte[1]))
        else $error("Bypass receive byte moved without a recovered clock fall");

    chk_pair_route: assert property (
        @(negedge clock) disable iff (!rst_n)
        !bypass_q && $past(!bypass_q) |-> rxParallelByte[0] ==
        (activeSel_q[0] ? $past(rxCoreByte[0]) : $past(rxCoreByte[1])))
        else $error("Pair output carries the wrong channel");

    chk_select_boundary: assert property (
        @(negedge clock) disable iff (!rst_n)
        activeSel_q[0] != $past(activeSel_q[0]) |-> $past(launch[0]))
        else $error("Pair select changed away from a byte boundary");

    chk_tx_capture: assert property (
        @(posedge clock) disable iff (!rst_n)
        ##1 txCoreByte == $past(txParallelByte))
        else $error("Transmit byte not captured on the rising edge");

    chk_oh_launch: assert property (
        @(posedge clock) disable iff (!rst_n)
        ohRise[0] && ohEnable_q[0] |=> overheadSerialOut[0] == $past(overheadCoreBit[0]))
        else $error("Overhead out bit not launched on clock rise");

    chk_oh_capture: assert property (
        @(posedge clock) disable iff (!rst_n)
        ohFall[0] && ohEnableLevel |=> overheadCoreIn[0] == $past(ohInLevel[0]))
        else $error("Overhead in bit not captured on clock fall");

    chk_serial_select: assert property (
        @(posedge clock) disable iff (!rst_n)
        $stable(serialLevel) |-> serialProtectApplied == serialLevel)
        else $error("Serial protection select not applied");

endmodule

// ---- test/fabric_user_model.sv ----
// Fabric-side user logic model driving the serial overhead clocks and data
module fabric_user_model (
    // Overhead link from the core
    input wire logic [7:0] overheadSerialOut,
    // Overhead link to the core
    output logic [7:0] overheadClock,
    output logic [7:0] overheadSerialIn,
    output logic txOverheadClockEnable,
    // Bits this model captured at each overhead clock rise
    output logic [7:0] capturedOut
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Overhead clock and data
    // ------------------------------------------------------------------
    // enable held active unless a test drops it on purpose

    // Clock stands low outside frames; the core only sees edges we make
    initial begin
        overheadClock = '0;
        overheadSerialIn = '0;
        capturedOut = '0;
        txOverheadClockEnable = 1'b1;
    end

    // Enable level for overhead insertion, changed just after a clock edge
    task automatic holdEnable(input logic en);
        txOverheadClockEnable <= en;
    endtask

    // rising-edge flops only
    // Capture first, then launch, so the old output is what we keep
    task automatic ohRise(input logic [7:0] din);
        capturedOut <= overheadSerialOut;
        overheadSerialIn <= din;
        overheadClock <= '1;
    endtask

    // Data stays put across the fall, where the core takes it
    task automatic ohFall();
        overheadClock <= '0;
    endtask
endmodule

// ---- test/sonet_core_fabric_port_tb.sv ----
// Self-checking testbench for the core to fabric boundary port
module sonet_core_fabric_port_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clock, rst_n, regWrite, regRead, txOverheadClockEnable;
    logic [3:0] regAddr, pairProtectSelect;
    logic [7:0] regWriteData, regReadData, recoveredClockIn, recoveredChannelClock;
    logic [7:0] overheadClock, overheadCoreBit, overheadSerialOut, overheadSerialIn;
    logic [7:0] overheadCoreIn, overheadOutEnableStatus, capturedOut;
    logic [7:0] serialProtectSelect, serialProtectApplied, prevIn, prevOut;
    logic [63:0] rxCoreByte, rxParallelByte, txParallelByte, txCoreByte, tv;
    logic [7:0] pats [4] = '{8'h96, 8'h3C, 8'hF0, 8'h69};
    int numErrors = 0, nTests = 0, cycles = 0;

    sonet_core_fabric_port sonet_core_fabric_port_i (
        .clock, .rst_n, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
        .rxCoreByte, .recoveredClockIn, .recoveredChannelClock, .rxParallelByte,
        .txParallelByte, .txCoreByte, .overheadClock, .txOverheadClockEnable,
        .overheadCoreBit, .overheadSerialOut, .overheadSerialIn, .overheadCoreIn,
        .overheadOutEnableStatus, .pairProtectSelect, .serialProtectSelect,
        .serialProtectApplied
    );

    fabric_user_model fabric_user_model_i (
        .overheadSerialOut, .overheadClock, .overheadSerialIn,
        .txOverheadClockEnable, .capturedOut
    );

    // 50 MHz system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard: the sequence needs about 150 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            numErrors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic checkPort(input string name, input logic [63:0] exp, got);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Strobe drops at the taking edge so back-to-back calls never clash
    task automatic regWr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic checkReg(input logic [3:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        checkPort($sformatf("register %h", a), 64'(exp), 64'(regReadData));
    endtask

    task automatic waitCycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Even output of each pair carries main when select high, else protect
    function automatic logic [63:0] expRx(input logic [63:0] d, input logic [3:0] sel);
        logic [63:0] r;
        r = d;
        for (int p = 0; p < 4; p++) begin
            if (!sel[p]) begin
                r[16*p +: 8] = d[16*p+8 +: 8];
            end
        end
        return r;
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {regWrite, regRead, regAddr, regWriteData} = '0;
        {rxCoreByte, txParallelByte, recoveredClockIn} = '0;
        {overheadCoreBit, serialProtectSelect, prevIn, prevOut} = '0;
        pairProtectSelect = 4'hF;
        // Sampler clears in one edge; three edges of reset are plenty
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        // Samplers restart from zero, so let them fill before the first request
        waitCycles(6);

        // Register map, read-only and unmapped places
        checkReg(sonet_port_pkg::REG_OH_ENABLE, 8'h00); // reset off
        checkReg(sonet_port_pkg::REG_MODE, 8'h00); // aligned at reset
        checkReg(sonet_port_pkg::REG_PAIR_STATUS, 8'h0F); // main at reset
        regWr(sonet_port_pkg::REG_OH_ENABLE, 8'hA5);
        regWr(sonet_port_pkg::REG_PAIR_STATUS, 8'hFF);
        regWr(4'hF, 8'h55);
        checkReg(sonet_port_pkg::REG_OH_ENABLE, 8'hA5); // readback
        checkPort("enable status", 64'(8'hA5), 64'(overheadOutEnableStatus)); // mirror
        checkReg(sonet_port_pkg::REG_PAIR_STATUS, 8'h0F); // write ignored
        checkReg(4'hF, 8'h00);
        $display("test registers done");

        // Transmit bytes taken on every rising edge, back to back
        for (int i = 0; i < 3; i++) begin
            tv = 64'h0123_4567_89AB_CDEF + 64'(i) * 64'h1111_1111_1111_1111;
            txParallelByte <= tv;
            waitCycles(1);
            checkPort("tx byte", tv, txCoreByte); // same edge
        end
        $display("test transmit done");

        // Aligned receive with mixed pair selects
        rxCoreByte <= 64'h0011_2233_4455_6677;
        pairProtectSelect <= 4'h5;
        waitCycles(6);
        checkPort("rx aligned", expRx(64'h0011_2233_4455_6677, 4'h5), rxParallelByte);
        checkReg(sonet_port_pkg::REG_PAIR_STATUS, 8'h05); // per pair
        rxCoreByte <= 64'h8899_AABB_CCDD_EEFF;
        #1;
        checkPort("rx before fall", expRx(64'h0011_2233_4455_6677, 4'h5), rxParallelByte);
        @(negedge clock);
        #1;
        checkPort("rx after fall", expRx(64'h8899_AABB_CCDD_EEFF, 4'h5), rxParallelByte);
        waitCycles(1);
        $display("test aligned receive done");

        // Serial-side selects, one per channel
        serialProtectSelect <= 8'h3C;
        waitCycles(6);
        checkPort("serial applied", 64'(8'h3C), 64'(serialProtectApplied)); // sampled
        checkReg(sonet_port_pkg::REG_SERIAL_STATUS, 8'h3C); // status
        $display("test serial select done");

        // Bypass receive: only a recovered-clock fall launches a byte
        regWr(sonet_port_pkg::REG_MODE, 8'h01);
        recoveredClockIn <= 8'hFF;
        pairProtectSelect <= 4'hF;
        rxCoreByte <= 64'h1357_9BDF_0246_8ACE;
        waitCycles(6);
        checkPort("recovered clock", 64'(8'hFF), 64'(recoveredChannelClock));
        checkPort("rx on rise", expRx(64'h8899_AABB_CCDD_EEFF, 4'h5), rxParallelByte);
        recoveredClockIn <= 8'h00;
        waitCycles(6);
        checkPort("rx bypass", expRx(64'h1357_9BDF_0246_8ACE, 4'hF), rxParallelByte);
        recoveredClockIn <= 8'hFF;
        rxCoreByte <= 64'hFEDC_BA98_7654_3210;
        pairProtectSelect <= 4'h0;
        waitCycles(6);
        checkPort("rx held", expRx(64'h1357_9BDF_0246_8ACE, 4'hF), rxParallelByte);
        recoveredClockIn <= 8'h00;
        waitCycles(6);
        checkPort("rx switched", expRx(64'hFEDC_BA98_7654_3210, 4'h0), rxParallelByte);
        $display("test bypass receive done");

        // Serial overhead in both directions; half the channels disabled
        for (int i = 0; i < 4; i++) begin
            overheadCoreBit <= pats[i];
            fabric_user_model_i.ohRise(~pats[i]);
            waitCycles(8);
            checkPort("oh out", 64'(pats[i] & 8'hA5), 64'(overheadSerialOut));
            checkPort("oh in held", 64'(prevIn), 64'(overheadCoreIn)); // not on rise
            if (i > 0) begin
                checkPort("fabric capture", 64'(prevOut), 64'(capturedOut)); // on rise
            end
            overheadCoreBit <= ~pats[i];
            fabric_user_model_i.ohFall();
            waitCycles(8);
            checkPort("oh in", 64'(pats[i] ^ 8'hFF), 64'(overheadCoreIn)); // on fall
            checkPort("oh out held", 64'(pats[i] & 8'hA5), 64'(overheadSerialOut));
            prevIn = ~pats[i];
            prevOut = pats[i] & 8'hA5;
        end
        // Capture stops while the fabric drops its overhead clock enable
        fabric_user_model_i.holdEnable(1'b0);
        waitCycles(6);
        fabric_user_model_i.ohRise(8'h5A);
        waitCycles(8);
        fabric_user_model_i.ohFall();
        waitCycles(8);
        checkPort("oh in gated", 64'(prevIn), 64'(overheadCoreIn));
        $display("test overhead done");
        stop_test();
    end
endmodule
